// file: verilog/slem_top.sv
// serial lane error monitor: per-lane error counters, threshold status, lane alignment
// enables and code-group lock flags behind a byte-wide register port.
// assumes register strobes and lane event inputs are synchronous to core_clk_in.
//
// Summary of operation
// RQ1: eight-bit lane alignment enable mask, one bit per lane, resets to 0x0f.
// RQ2: disparity status bit sets when that lane's disparity count reaches threshold.
// RQ3: disparity command bit 7 clears the addressed lane's disparity irq.
// RQ4: disparity command bit 6 stops the addressed lane's disparity counter.
// RQ5: disparity command bit 5 zeroes the addressed lane's disparity counter.
// RQ6: bad symbol status bit sets when that lane's count reaches threshold.
// RQ7: bad symbol command bit 7 clears the addressed lane's irq.
// RQ8: stray control status bit sets when that lane's count reaches threshold.
// RQ9: stray control command bit 7 clears the addressed lane's irq.
// RQ10: bit 6 of bad symbol and stray control commands disables that counter.
// RQ11: bit 5 of bad symbol and stray control commands clears that counter.
// RQ12: command bits 2 to 0 pick the lane; bits 4 and 3 are reserved.
// RQ13: live per-lane lock flags, one means locked, reset to zero.
// RQ14: writing bit 7 of the lock flag register clears the lock-loss pending flag.
// RQ15: any lane losing lock asserts the sync request toward the transmitter.
// RQ16: counter select code 10 reads back the stray control counter.
// RQ17: lane and counter select written, the chosen count reads at the same address.
// RQ18: enabled counters count each error; status stays until the counter clears.
`timescale 1ns/1ns
`include "slem_cfg.svh"
module slem_top (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // register port
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [`SLEM_ADDR_W-1:0] addr_in,
    input wire slem_pkg::slem_byte_t wdata_in,
    output slem_pkg::slem_byte_t rdata_out,
    // lane events from the decoders
    input wire logic [`SLEM_LANES-1:0] disparity_err_in,
    input wire logic [`SLEM_LANES-1:0] bad_symbol_err_in,
    input wire logic [`SLEM_LANES-1:0] stray_control_err_in,
    input wire logic [`SLEM_LANES-1:0] symbol_lock_in,
    input wire slem_pkg::slem_byte_t threshold_in,
    // link control and status
    output logic [`SLEM_LANES-1:0] lane_alignment_enable_out,
    output logic sync_request_n_out,
    output logic lock_lost_pending_out,
    output logic [`SLEM_LANES-1:0] disparity_error_status_out,
    output logic [`SLEM_LANES-1:0] bad_symbol_status_out,
    output logic [`SLEM_LANES-1:0] stray_control_status_out,
    output logic [`SLEM_LANES-1:0] disparity_irq_out,
    output logic [`SLEM_LANES-1:0] bad_symbol_irq_out,
    output logic [`SLEM_LANES-1:0] stray_control_irq_out
);
    // per-type views; index 0 disparity, 1 bad symbol, 2 stray control
    logic [`SLEM_LANES-1:0] err_w [`SLEM_TYPES];
    logic [`SLEM_LANES-1:0] en_w [`SLEM_TYPES];
    logic [`SLEM_LANES-1:0] stat_w [`SLEM_TYPES];
    logic [`SLEM_LANES-1:0] irq_w [`SLEM_TYPES];
    slem_pkg::slem_byte_t cnt_w [`SLEM_TYPES][`SLEM_LANES];
    logic [`SLEM_TYPES-1:0] cmd_hit;
    logic [`SLEM_ADDR_W-1:0] cmd_addr [`SLEM_TYPES];
    slem_pkg::slem_lane_t cmd_lane;
    slem_pkg::slem_lane_t sel_lane_reg;
    slem_pkg::slem_cnt_sel_t sel_cnt_reg;
    logic [`SLEM_LANES-1:0] lock_flags_reg;
    logic [`SLEM_LANES-1:0] lock_drop;
    logic wr_hit_align;
    logic wr_hit_sel;
    logic wr_hit_lock;
    slem_pkg::slem_byte_t rdata_next;
    slem_pkg::slem_byte_t readback_cnt;

    assign err_w[0] = disparity_err_in;
    assign err_w[1] = bad_symbol_err_in;
    assign err_w[2] = stray_control_err_in;
    assign cmd_addr[0] = `SLEM_ADDR_DISPARITY;
    assign cmd_addr[1] = `SLEM_ADDR_BAD_SYMBOL;
    assign cmd_addr[2] = `SLEM_ADDR_STRAY_CTRL;

    // write decode, qualified once by the clock enable so every command is a clean pulse
    assign wr_hit_align = ce_in && wr_en_in && (addr_in == `SLEM_ADDR_ALIGN);
    assign wr_hit_sel = ce_in && wr_en_in && (addr_in == `SLEM_ADDR_READBACK);
    assign wr_hit_lock = ce_in && wr_en_in && (addr_in == `SLEM_ADDR_LOCK);
    assign cmd_lane = wdata_in[`SLEM_CMD_LANE_MSB:`SLEM_CMD_LANE_LSB]; // see RQ12

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // one counter per lane per error type; reserved bits 4 and 3 are simply not decoded
    genvar t, l;
    generate
        for (t = 0; t < `SLEM_TYPES; t = t + 1) begin : g_type
            assign cmd_hit[t] = ce_in && wr_en_in && (addr_in == cmd_addr[t]);
            for (l = 0; l < `SLEM_LANES; l = l + 1) begin : g_lane
                logic sel_me;
                assign sel_me = cmd_hit[t] && (cmd_lane == 3'(l)); // see RQ12
                slem_err_counter u_cnt (
                    .core_clk_in(core_clk_in),
                    .rst_n_in(rst_n_in),
                    .ce_in(ce_in),
                    .err_in(err_w[t][l]), // see RQ18
                    .disable_in(sel_me && wdata_in[`SLEM_CMD_DISABLE_BIT]), // see RQ4, see RQ10
                    .clear_in(sel_me && wdata_in[`SLEM_CMD_CLEAR_BIT]), // see RQ5, see RQ11
                    .irq_clear_in(sel_me && wdata_in[`SLEM_CMD_IRQ_CLEAR_BIT]), // see RQ3, see RQ7, see RQ9
                    .threshold_in(threshold_in),
                    .count_out(cnt_w[t][l]),
                    .enabled_out(en_w[t][l]),
                    .status_out(stat_w[t][l]), // see RQ2, see RQ6, see RQ8
                    .irq_out(irq_w[t][l])
                );

                // counting follows each error while enabled and not being cleared
                count_step_a: assert property (ce_in && err_w[t][l] && en_w[t][l] && !cmd_hit[t] // see RQ18
                    && cnt_w[t][l] != `SLEM_CNT_MAX |=> cnt_w[t][l] == $past(cnt_w[t][l]) + 8'h01)
                    else $error("error counter did not step on an enabled error");
                // reaching the threshold sets the status on the next edge and it holds
                status_reach_a: assert property (ce_in && cnt_w[t][l] >= threshold_in // see RQ2, see RQ6, see RQ8
                    && !cmd_hit[t] |=> stat_w[t][l] ##1 (stat_w[t][l] || $past(cmd_hit[t])))
                    else $error("threshold status missing or dropped without a clear");
                // counter clear zeroes the count and the status
                count_clear_a: assert property (sel_me && wdata_in[`SLEM_CMD_CLEAR_BIT] // see RQ5, see RQ11
                    |=> cnt_w[t][l] == 8'h00 && !stat_w[t][l])
                    else $error("counter clear did not zero the count");
                // a disable freezes the count from the write edge on
                count_freeze_a: assert property (sel_me && wdata_in[`SLEM_CMD_DISABLE_BIT] // see RQ4, see RQ10
                    && !wdata_in[`SLEM_CMD_CLEAR_BIT] |=> !en_w[t][l] && cnt_w[t][l] == $past(cnt_w[t][l])
                    ##1 ($past(cmd_hit[t]) || !$past(ce_in) || $stable(cnt_w[t][l])))
                    else $error("disabled counter kept counting");
                // irq clear with the status already standing leaves the irq low
                irq_clear_a: assert property (sel_me // see RQ3, see RQ7, see RQ9
                    && wdata_in[`SLEM_CMD_IRQ_CLEAR_BIT] && stat_w[t][l] |=> !irq_w[t][l])
                    else $error("irq clear for the addressed lane was lost");
                // an irq only rises together with its status; a later counter clear may leave it pending
                irq_status_a: assert property ($rose(irq_w[t][l]) |-> stat_w[t][l]) // see RQ18
                    else $error("irq raised without threshold status");
            end
        end
    endgenerate

    // status and irq vectors leave straight from the counter flops
    assign disparity_error_status_out = stat_w[0];
    assign bad_symbol_status_out = stat_w[1];
    assign stray_control_status_out = stat_w[2];
    assign disparity_irq_out = irq_w[0];
    assign bad_symbol_irq_out = irq_w[1];
    assign stray_control_irq_out = irq_w[2];

    // lane alignment mask, software owned
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lane_alignment_enable_out <= `SLEM_ALIGN_RESET; // see RQ1
        end else if (wr_hit_align) begin
            lane_alignment_enable_out <= wdata_in; // see RQ1
        end
    end

    // readback selection; the select sits in the same word the count is read from
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sel_lane_reg <= 3'h0;
            sel_cnt_reg <= `SLEM_SEL_DISPARITY;
        end else if (wr_hit_sel) begin
            sel_lane_reg <= wdata_in[`SLEM_SEL_LANE_MSB:`SLEM_SEL_LANE_LSB]; // see RQ17
            sel_cnt_reg <= wdata_in[`SLEM_SEL_CNT_MSB:`SLEM_SEL_CNT_LSB]; // see RQ17
        end
    end

    // live lock flags sampled every enabled cycle; a falling flag marks a loss
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lock_flags_reg <= `SLEM_LOCK_RESET; // see RQ13
        end else if (ce_in) begin
            lock_flags_reg <= symbol_lock_in; // see RQ13
        end
    end

    assign lock_drop = lock_flags_reg & ~symbol_lock_in;

    // pending lock-loss flag; a loss in the clearing cycle keeps it set
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            lock_lost_pending_out <= 1'b0;
        end else if (ce_in) begin
            if (|lock_drop) begin
                lock_lost_pending_out <= 1'b1;
            end else if (wr_hit_lock && wdata_in[`SLEM_LOCK_IRQ_CLEAR_BIT]) begin
                lock_lost_pending_out <= 1'b0; // see RQ14
            end
        end
    end

    // sync request is held low while any lane lacks lock, so the link restarts from reset
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync_request_n_out <= 1'b0;
        end else if (ce_in) begin
            sync_request_n_out <= &symbol_lock_in; // see RQ15
        end
    end

    // counter readback mux; the unused select code reads zero
    always_comb begin
        readback_cnt = 8'h00;
        unique case (sel_cnt_reg)
            `SLEM_SEL_DISPARITY: readback_cnt = cnt_w[0][sel_lane_reg]; // see RQ17
            `SLEM_SEL_BAD_SYMBOL: readback_cnt = cnt_w[1][sel_lane_reg]; // see RQ17
            `SLEM_SEL_STRAY_CTRL: readback_cnt = cnt_w[2][sel_lane_reg]; // see RQ16
            default: readback_cnt = 8'h00;
        endcase
    end

    // read decode; command halves of shared offsets read their status vectors
    always_comb begin
        rdata_next = 8'h00;
        unique case (addr_in)
            `SLEM_ADDR_READBACK: rdata_next = readback_cnt;
            `SLEM_ADDR_ALIGN: rdata_next = lane_alignment_enable_out;
            `SLEM_ADDR_DISPARITY: rdata_next = stat_w[0]; // see RQ2
            `SLEM_ADDR_BAD_SYMBOL: rdata_next = stat_w[1]; // see RQ6
            `SLEM_ADDR_STRAY_CTRL: rdata_next = stat_w[2]; // see RQ8
            `SLEM_ADDR_LOCK: rdata_next = lock_flags_reg; // see RQ13
            default: rdata_next = 8'h00;
        endcase
    end

    // read data is registered and holds until the next read
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (ce_in && rd_en_in) begin
            rdata_out <= rdata_next;
        end
    end

    // alignment mask comes out of reset at its default
    align_reset_a: assert property ($rose(rst_n_in) |-> lane_alignment_enable_out == `SLEM_ALIGN_RESET) // see RQ1
        else $error("alignment mask reset value wrong");

    // alignment mask takes a write and keeps it while no write lands
    align_write_a: assert property (wr_hit_align |=> lane_alignment_enable_out == $past(wdata_in) // see RQ1
        ##1 ($past(wr_hit_align) || $stable(lane_alignment_enable_out)))
        else $error("alignment mask write not taken");

    // lock flags follow the lanes one enabled cycle late
    lock_follow_a: assert property (ce_in |=> lock_flags_reg == $past(symbol_lock_in)) // see RQ13
        else $error("lock flags do not follow the lanes");

    // a lane without lock forces the sync request low on the next edge
    sync_request_a: assert property (ce_in && !(&symbol_lock_in) |=> !sync_request_n_out) // see RQ15
        else $error("sync request not asserted on lost lock");

    // full lock releases the sync request
    sync_release_a: assert property (ce_in && (&symbol_lock_in) |=> sync_request_n_out) // see RQ15
        else $error("sync request held with all lanes locked");

    // pending flag clears on the write unless a new loss arrives in the same cycle
    lock_clear_a: assert property (wr_hit_lock && wdata_in[`SLEM_LOCK_IRQ_CLEAR_BIT] && !(|lock_drop) // see RQ14
        |=> !lock_lost_pending_out)
        else $error("lock loss pending flag not cleared");

    // a loss always raises the pending flag, even against a clear
    lock_set_a: assert property (ce_in && (|lock_drop) |=> lock_lost_pending_out) // see RQ14
        else $error("lock loss not recorded");

    // select code 10 returns the stray control count of the chosen lane
    stray_readback_a: assert property (ce_in && rd_en_in && addr_in == `SLEM_ADDR_READBACK // see RQ16
        && sel_cnt_reg == `SLEM_SEL_STRAY_CTRL |=> rdata_out == $past(cnt_w[2][sel_lane_reg]))
        else $error("stray control counter readback wrong");

    // codes 00 and 01 return the disparity and bad symbol counts
    cnt_readback_a: assert property (ce_in && rd_en_in && addr_in == `SLEM_ADDR_READBACK // see RQ17
        && sel_cnt_reg != `SLEM_SEL_STRAY_CTRL && sel_cnt_reg[1] == 1'b0
        |=> rdata_out == $past(cnt_w[sel_cnt_reg[0]][sel_lane_reg]))
        else $error("counter readback wrong");

    // main scenarios
    disp_irq_c: cover property (ce_in && disparity_err_in[0] ##[1:20] disparity_irq_out[0]);
    lock_loss_c: cover property (lock_lost_pending_out ##[1:20] !lock_lost_pending_out);
    disable_c: cover property (cmd_hit[1] && wdata_in[`SLEM_CMD_DISABLE_BIT] ##1 !en_w[1][wdata_in[2:0]]);
    readback_c: cover property (wr_hit_sel ##[1:10] (ce_in && rd_en_in && addr_in == `SLEM_ADDR_READBACK));
endmodule

// file: verilog/slem_cfg.svh
// constants for the serial lane error monitor: register offsets, field positions,
// reset values and counter codes. assumes inclusion by bare name from the design files.
`ifndef SLEM_CFG_SVH
`define SLEM_CFG_SVH

// register bus geometry
`define SLEM_ADDR_W 12
`define SLEM_DATA_W 8
`define SLEM_LANES 8
`define SLEM_TYPES 3

// register offsets
`define SLEM_ADDR_READBACK 12'h46b
`define SLEM_ADDR_ALIGN 12'h46c
`define SLEM_ADDR_DISPARITY 12'h46d
`define SLEM_ADDR_BAD_SYMBOL 12'h46e
`define SLEM_ADDR_STRAY_CTRL 12'h46f
`define SLEM_ADDR_LOCK 12'h470

// command register fields
`define SLEM_CMD_IRQ_CLEAR_BIT 7
`define SLEM_CMD_DISABLE_BIT 6
`define SLEM_CMD_CLEAR_BIT 5
`define SLEM_CMD_LANE_MSB 2
`define SLEM_CMD_LANE_LSB 0

// readback select fields
`define SLEM_SEL_LANE_MSB 6
`define SLEM_SEL_LANE_LSB 4
`define SLEM_SEL_CNT_MSB 1
`define SLEM_SEL_CNT_LSB 0
`define SLEM_SEL_DISPARITY 2'h0
`define SLEM_SEL_BAD_SYMBOL 2'h1
`define SLEM_SEL_STRAY_CTRL 2'h2

// lock flag register: writing this bit clears the pending lock-loss flag
`define SLEM_LOCK_IRQ_CLEAR_BIT 7

// reset values and counter limit
`define SLEM_ALIGN_RESET 8'h0f
`define SLEM_LOCK_RESET 8'h00
`define SLEM_CNT_MAX 8'hff

`endif

// file: verilog/slem_pkg.sv
// types shared by the serial lane error monitor files.
// assumes nothing beyond a SystemVerilog compiler; constants live in slem_cfg.svh.
package slem_pkg;
    typedef logic [7:0] slem_byte_t;
    typedef logic [2:0] slem_lane_t;
    typedef logic [1:0] slem_cnt_sel_t;
endpackage

// file: verilog/slem_err_counter.sv
// one error counter for one lane and one error type, with threshold status and irq flag.
// assumes single-cycle command pulses already qualified by the clock enable.
`timescale 1ns/1ns
`include "slem_cfg.svh"
module slem_err_counter (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // error event and commands
    input wire logic err_in,
    input wire logic disable_in,
    input wire logic clear_in,
    input wire logic irq_clear_in,
    input wire slem_pkg::slem_byte_t threshold_in,
    // state
    output slem_pkg::slem_byte_t count_out,
    output logic enabled_out,
    output logic status_out,
    output logic irq_out
);
    logic hit;

    assign hit = (count_out >= threshold_in);

    // disable is sticky; a counter clear arms the counter again unless disabled in the same write
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            enabled_out <= 1'b1;
        end else if (ce_in) begin
            if (disable_in) begin
                enabled_out <= 1'b0;
            end else if (clear_in) begin
                enabled_out <= 1'b1;
            end
        end
    end

    // saturating count so a long burst never wraps back under the threshold
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            count_out <= 8'h00;
        end else if (ce_in) begin
            if (clear_in) begin
                count_out <= 8'h00;
            end else if (err_in && enabled_out && !disable_in && count_out != `SLEM_CNT_MAX) begin
                count_out <= count_out + 8'h01;
            end
        end
    end

    // status holds until the count itself is cleared, even if the threshold moves
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            status_out <= 1'b0;
        end else if (ce_in) begin
            if (clear_in) begin
                status_out <= 1'b0;
            end else if (hit) begin
                status_out <= 1'b1;
            end
        end
    end

    // irq raised on the first reach of the threshold; a new reach beats an irq clear but not a counter clear
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else if (ce_in) begin
            if (hit && !status_out && !clear_in) begin
                irq_out <= 1'b1;
            end else if (irq_clear_in) begin
                irq_out <= 1'b0;
            end
        end
    end
endmodule

// file: verif/slem_lane_tx_model.sv
// lane transmitter model: per-lane error pulses and code-group lock levels.
// assumes its tasks are called from one bench process, in step with core_clk_in.
`timescale 1ns/1ns
module slem_lane_tx_model (
    // clock
    input wire logic core_clk_in,
    // lane events toward the monitor
    output logic [7:0] disparity_err_out,
    output logic [7:0] bad_symbol_err_out,
    output logic [7:0] stray_control_err_out,
    output logic [7:0] symbol_lock_out
);
    // quiet and unlocked at power-up, as a link that has not trained yet
    initial begin
        disparity_err_out = 8'h00;
        bad_symbol_err_out = 8'h00;
        stray_control_err_out = 8'h00;
        symbol_lock_out = 8'h00;
    end

    // drive one error type; kind 0 disparity, 1 not-in-table, 2 stray control
    task automatic put(input int kind, input logic [7:0] m);
        case (kind)
            0: disparity_err_out <= m;
            1: bad_symbol_err_out <= m;
            default: stray_control_err_out <= m;
        endcase
    endtask

    // one pulse per error; gap 0 sends errors back to back, larger gaps play a slow link
    task automatic send_errors(input int kind, input int lane, input int num, input int gap);
        for (int i = 0; i < num; i++) begin
            @(posedge core_clk_in);
            put(kind, 8'h01 << lane);
            repeat (gap) begin
                @(posedge core_clk_in);
                put(kind, 8'h00);
            end
        end
        @(posedge core_clk_in);
        put(kind, 8'h00);
    endtask

    // lock is a level per lane, changed just after an edge
    task automatic set_lock(input logic [7:0] m);
        @(posedge core_clk_in);
        symbol_lock_out <= m;
    endtask
endmodule

// file: verif/serial_lane_error_monitor_test.sv
// self-checking bench for slem_top: counters, commands, readback, alignment mask, lock flags.
// assumes the lane transmitter model drives all lane events; ce_in drops once to show a frozen write.
`timescale 1ns/1ns
`include "slem_cfg.svh"
module serial_lane_error_monitor_test;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    slem_pkg::slem_byte_t wdata_in = 8'h00;
    slem_pkg::slem_byte_t threshold_in = 8'h02;
    slem_pkg::slem_byte_t rdata_out, rv;
    logic [7:0] de, be, se, lk, align, dst, bst, sst, dirq, birq, sirq;
    logic sync_n, pend;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int lane, num, thr;

    // 25 MHz core clock
    always #20 core_clk_in = ~core_clk_in;

    slem_lane_tx_model u_tx (.core_clk_in(core_clk_in), .disparity_err_out(de), .bad_symbol_err_out(be),
        .stray_control_err_out(se), .symbol_lock_out(lk));

    slem_top u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .disparity_err_in(de), .bad_symbol_err_in(be), .stray_control_err_in(se), .symbol_lock_in(lk),
        .threshold_in(threshold_in), .lane_alignment_enable_out(align), .sync_request_n_out(sync_n),
        .lock_lost_pending_out(pend), .disparity_error_status_out(dst), .bad_symbol_status_out(bst),
        .stray_control_status_out(sst), .disparity_irq_out(dirq), .bad_symbol_irq_out(birq),
        .stray_control_irq_out(sirq));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a hang is cut off well beyond the few hundred cycles the tests need
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic check(input string what, input slem_pkg::slem_byte_t exp, input slem_pkg::slem_byte_t got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write, held for exactly one taken edge
    task automatic wr(input logic [11:0] a, input slem_pkg::slem_byte_t d);
        @(posedge core_clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge core_clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask

    // read data lands on the taken edge itself
    task automatic rd_check(input logic [11:0] a, input slem_pkg::slem_byte_t exp, input string what);
        @(posedge core_clk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge core_clk_in);
        rd_en_in <= 1'b0;
        #1;
        check(what, exp, rdata_out);
    endtask

    // threshold status is only this lane's bit, since each round clears its counter
    function automatic slem_pkg::slem_byte_t exp_status(input int n, input int t, input int l);
        return (n >= t) ? (8'h01 << l) : 8'h00;
    endfunction

    function automatic slem_pkg::slem_byte_t irq_of(input int k);
        return (k == 0) ? dirq : ((k == 1) ? birq : sirq);
    endfunction

    function automatic slem_pkg::slem_byte_t stat_of(input int k);
        return (k == 0) ? dst : ((k == 1) ? bst : sst);
    endfunction

    initial begin
        rv = $urandom(32'hc6ad);
        repeat (12) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        // alignment mask reset value, then a random pattern round trip
        rd_check(`SLEM_ADDR_ALIGN, 8'h0f, "align reset");
        rv = 8'($urandom);
        wr(`SLEM_ADDR_ALIGN, rv);
        check("align out", rv, align);
        rd_check(`SLEM_ADDR_ALIGN, rv, "align read");
        // a low clock enable ignores a write; a mid-run reset brings the default back
        ce_in <= 1'b0;
        wr(`SLEM_ADDR_ALIGN, ~rv);
        check("align frozen", rv, align);
        ce_in <= 1'b1;
        rst_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        rd_check(`SLEM_ADDR_ALIGN, 8'h0f, "align rereset");
        $display("test alignment done");
        // each error type twice: a corner on lane 7 at exactly the threshold, then random
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 3; k++) begin
                thr = (r == 0) ? 3 : $urandom_range(4, 1);
                lane = (r == 0) ? 7 : $urandom_range(7, 0);
                num = (r == 0) ? thr : $urandom_range(6, 1);
                threshold_in <= 8'(thr);
                wr(`SLEM_ADDR_READBACK, {1'b0, 3'(lane), 2'b00, 2'(k)});
                u_tx.send_errors(k, lane, num, $urandom_range(2, 0));
                repeat (2) @(posedge core_clk_in);
                rd_check(`SLEM_ADDR_READBACK, 8'(num), "count");
                rd_check(`SLEM_ADDR_DISPARITY + 12'(k), exp_status(num, thr, lane), "status");
                check("irq set", exp_status(num, thr, lane), irq_of(k));
                check("status out", exp_status(num, thr, lane), stat_of(k));
                wr(`SLEM_ADDR_DISPARITY + 12'(k), 8'h80 | 8'(lane));
                check("irq clear", 8'h00, irq_of(k));
                wr(`SLEM_ADDR_DISPARITY + 12'(k), 8'h40 | 8'(lane));
                u_tx.send_errors(k, lane, 2, 0);
                repeat (2) @(posedge core_clk_in);
                rd_check(`SLEM_ADDR_READBACK, 8'(num), "disabled count");
                // reserved bits set alongside the clear must not move the lane
                wr(`SLEM_ADDR_DISPARITY + 12'(k), 8'h38 | 8'(lane));
                rd_check(`SLEM_ADDR_READBACK, 8'h00, "cleared count");
                rd_check(`SLEM_ADDR_DISPARITY + 12'(k), 8'h00, "cleared status");
            end
            $display("test counters round %0d done", r);
        end
        // the unused select code reads zero even with a count standing
        wr(`SLEM_ADDR_READBACK, 8'h03);
        u_tx.send_errors(0, 0, 2, 0);
        rd_check(`SLEM_ADDR_READBACK, 8'h00, "unused select");
        // lock flags and sync request: unlocked after reset, then lock, loss and clear
        check("sync idle", 8'h00, {7'h00, sync_n});
        rd_check(`SLEM_ADDR_LOCK, 8'h00, "lock reset");
        u_tx.set_lock(8'hff);
        repeat (2) @(posedge core_clk_in);
        #1;
        check("sync locked", 8'h01, {7'h00, sync_n});
        rd_check(`SLEM_ADDR_LOCK, 8'hff, "lock flags");
        lane = $urandom_range(7, 0);
        u_tx.set_lock(~(8'h01 << lane));
        repeat (2) @(posedge core_clk_in);
        #1;
        check("sync lost", 8'h00, {7'h00, sync_n});
        check("pending set", 8'h01, {7'h00, pend});
        rd_check(`SLEM_ADDR_LOCK, ~(8'h01 << lane), "lock loss");
        u_tx.set_lock(8'hff);
        wr(`SLEM_ADDR_LOCK, 8'h80);
        check("pending clear", 8'h00, {7'h00, pend});
        rd_check(12'h471, 8'h00, "unmapped");
        $display("test lock done");
        conclude();
    end
endmodule
